/* iet_defs.vh */
// Register map, field positions, reset values and timing counts of the interrupt block
`ifndef IET_DEFS_VH
`define IET_DEFS_VH
// Register byte offsets
`define IET_CFG      12'h100
`define IET_SSEL     12'h104
`define IET_ETLC     12'h108
`define IET_ROUTE    12'h10C
`define IET_PAT      12'h110
`define IET_GATE     12'h114
`define IET_STAT     12'h118
`define IET_CLR      12'h11C
`define IET_IEN      12'h120
// Node block at 0x000-0x0FC, channel block at 0x200-0x27C
`define IET_NODE_SEL 4'h0
`define IET_CH_SEL   5'h04
// Channel register index inside a 16-byte channel slot
`define IET_CR_SRC   2'h0
`define IET_CR_DST   2'h1
`define IET_CR_CNT   2'h2
`define IET_CR_CTL   2'h3
// Node control fields
`define IET_N_REQ    0
`define IET_N_EN     1
`define IET_N_PRI_LO 2
`define IET_N_PRI_HI 5
`define IET_N_XFER   6
`define IET_N_CH_LO  7
`define IET_N_CH_HI  9
// Channel control fields
`define IET_C_INCS   0
`define IET_C_INCD   1
`define IET_C_CONT   2
`define IET_C_WORD   3
// Output gating modes
`define IET_G_BLOCK  2'h0
`define IET_G_PASS   2'h1
`define IET_G_MATCH  2'h2
`define IET_G_MISS   2'h3
// Reset values
`define IET_RST_NODE 10'h000
`define IET_RST_W32  32'h0000_0000
// Response time in clocks, with and without the jump cache
`define IET_RESP_JC  4'h7
`define IET_RESP_NC  4'hB
`endif

/* iet_etl.v */
// Edge trigger logic channel of the external request router
`timescale 1ns/100ps
module iet_edge_trig
(
    // Clock, reset and enable
    input  wire clock,
    input  wire rst_n,
    input  wire ce,
    // Input level and edge selection
    input  wire level,
    input  wire rise_en,
    input  wire fall_en,
    // Detected event
    output wire event_pulse
);
    reg prev;

    // Remember the last sampled level
    always @(posedge clock)
    begin
        if (!rst_n)
            prev <= 1'b0;
        else if (ce)
            prev <= level;
    end

    // Rising, falling or both edges as selected
    assign event_pulse = ce & ((rise_en & level & ~prev) | (fall_en & ~level & prev));
endmodule // iet_edge_trig

/* iet_top.v */
// Interrupt nodes, event transfer channels, request router and trap path
`timescale 1ns/100ps
`include "iet_defs.vh"
// Operation
// [RULE1] Per node, software picks interrupt service or event transfer service.
// [RULE2] Interrupt service forces a branch to the node's vector table entry.
// [RULE3] A transfer service takes exactly one cycle, with no vector branch.
// [RULE4] A transfer moves a byte or word, then steps source and/or destination.
// [RULE5] Each transfer decrements the channel counter unless continuous mode is set.
// [RULE6] With the counter at zero, the next request becomes a normal interrupt.
// [RULE7] Eight independent event transfer channels.
// [RULE8] Response is 7 clocks with jump cache, 11 clocks without.
// [RULE9] 64 nodes, each with request flag, enable flag and priority field.
// [RULE10] Shared nodes take their source from programmable selection registers.
// [RULE11] Router: 4 edge channels, routing matrix, 4 output gating units.
// [RULE12] Each router channel detects rising, falling or both edges.
// [RULE13] Each gating unit passes events on pattern match or on pattern miss.
// [RULE14] A run-time error raises a trap, serviced like an interrupt.
// [RULE15] Highest priority enabled pending node wins; lowest index breaks ties.
// [RULE16] A node's request flag clears when its request is accepted.
module iet_top #(
    parameter          AW       = 16,
    parameter          CW       = 8,
    parameter [AW-1:0] VEC_BASE = 16'h0000,
    parameter [AW-1:0] TRAP_VEC = 16'h0100
)
(
    // Clock, reset and enable
    input  wire          clock,
    input  wire          rst_n,
    input  wire          ce,
    // APB slave
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    // Request sources
    input  wire [63:0]   src_req,
    input  wire [7:0]    alt_src,
    input  wire [3:0]    router_in,
    input  wire          trap_req,
    // Core side
    output reg           branch,
    output reg  [AW-1:0] branch_addr,
    output reg           xfer_go,
    output reg  [AW-1:0] xfer_src,
    output reg  [AW-1:0] xfer_dst,
    output reg           xfer_word,
    output reg  [3:0]    router_trig,
    output reg           irq
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RESP = 2'b10;

    reg  [9:0]    node [0:63];
    reg  [AW-1:0] sptr [0:7];
    reg  [AW-1:0] dptr [0:7];
    reg  [CW-1:0] cnt  [0:7];
    reg  [3:0]    cctl [0:7];
    reg           jc;
    reg  [15:0]   ssel;
    reg  [7:0]    etlc;
    reg  [15:0]   route;
    reg  [31:0]   pat;
    reg  [7:0]    gate;
    reg  [8:0]    stat;
    reg  [8:0]    ien;
    reg  [1:0]    state;
    reg  [3:0]    rcnt;
    reg           trap_pend;
    reg  [31:0]   rd_val;
    reg           hit;
    reg  [63:0]   src_eff;
    reg  [3:0]    next_trig;
    reg           win_ok;
    reg  [5:0]    win_idx;
    reg  [3:0]    win_pri;
    reg           comb;
    reg           mt;
    wire [3:0]    evt;
    integer       i;
    integer       j;
    integer       k;
    integer       m;

    // APB decode; writes land at the edge where pready is sampled high
    wire       acc      = psel & penable & ce;
    wire       wr       = acc & pready & pwrite;
    wire       node_sel = (paddr[11:8] == `IET_NODE_SEL);
    wire       ch_sel   = (paddr[11:7] == `IET_CH_SEL);
    wire [5:0] nidx     = paddr[7:2];
    wire [2:0] cidx     = paddr[6:4];
    wire [1:0] creg     = paddr[3:2];

    // Read data and address check
    always @*
    begin
        rd_val = `IET_RST_W32;
        hit    = 1'b1;
        if (node_sel)
            rd_val = {22'h00_0000, node[nidx]};
        else if (ch_sel)
        begin
            case (creg)
                `IET_CR_SRC: rd_val = {{(32-AW){1'b0}}, sptr[cidx]};
                `IET_CR_DST: rd_val = {{(32-AW){1'b0}}, dptr[cidx]};
                `IET_CR_CNT: rd_val = {{(32-CW){1'b0}}, cnt[cidx]};
                default:     rd_val = {28'h000_0000, cctl[cidx]};
            endcase
        end
        else
        begin
            case (paddr)
                `IET_CFG:   rd_val = {31'h0000_0000, jc};
                `IET_SSEL:  rd_val = {16'h0000, ssel};
                `IET_ETLC:  rd_val = {24'h00_0000, etlc};
                `IET_ROUTE: rd_val = {16'h0000, route};
                `IET_PAT:   rd_val = pat;
                `IET_GATE:  rd_val = {24'h00_0000, gate};
                `IET_STAT:  rd_val = {23'h00_0000, stat};
                `IET_CLR:   rd_val = `IET_RST_W32;
                `IET_IEN:   rd_val = {23'h00_0000, ien};
                default:    hit    = 1'b0;
            endcase
        end
    end

    // Edge detection on the four router inputs
    genvar gv;
    generate
        for (gv = 0; gv < 4; gv = gv + 1)
        begin : g_edge
            iet_edge_trig u_edge_trig
            (
                .clock      (clock),
                .rst_n      (rst_n),
                .ce         (ce),
                .level      (router_in[gv]),
                .rise_en    (etlc[gv]),
                .fall_en    (etlc[4 + gv]),
                .event_pulse(evt[gv])
            ); // [RULE11] [RULE12]
        end
    endgenerate

    // Routing matrix and output gating units
    always @*
    begin
        next_trig = 4'h0;
        comb      = 1'b0;
        mt        = 1'b0;
        for (k = 0; k < 4; k = k + 1)
        begin
            comb = |(evt & route[4*k +: 4]); // [RULE11]
            mt   = (((router_in ^ pat[16 + 4*k +: 4]) & pat[4*k +: 4]) == 4'h0);
            case (gate[2*k +: 2])
                `IET_G_PASS:  next_trig[k] = comb;
                `IET_G_MATCH: next_trig[k] = comb & mt; // [RULE13]
                `IET_G_MISS:  next_trig[k] = comb & ~mt; // [RULE13]
                default:      next_trig[k] = 1'b0;
            endcase
        end
    end

    // Dedicated sources, with nodes 56..63 chosen by the select register
    always @*
    begin
        src_eff = src_req;
        for (m = 0; m < 8; m = m + 1)
        begin
            case (ssel[2*m +: 2])
                2'h0:    src_eff[56 + m] = src_req[56 + m];
                2'h1:    src_eff[56 + m] = router_trig[m % 4]; // [RULE10]
                2'h2:    src_eff[56 + m] = alt_src[m]; // [RULE10]
                default: src_eff[56 + m] = 1'b0;
            endcase
        end
    end

    // Pick the enabled pending node of highest priority
    always @*
    begin
        win_ok  = 1'b0;
        win_idx = 6'h00;
        win_pri = 4'h0;
        for (i = 0; i < 64; i = i + 1)
        begin
            if (node[i][`IET_N_REQ] && node[i][`IET_N_EN] &&
                (!win_ok || node[i][`IET_N_PRI_HI:`IET_N_PRI_LO] > win_pri))
            begin
                win_ok  = 1'b1; // [RULE15]
                win_idx = i[5:0];
                win_pri = node[i][`IET_N_PRI_HI:`IET_N_PRI_LO];
            end
        end
    end

    // Service decision for the winning node
    wire [2:0]    gch       = node[win_idx][`IET_N_CH_HI:`IET_N_CH_LO];
    wire          g_cont    = cctl[gch][`IET_C_CONT];
    wire          g_word    = cctl[gch][`IET_C_WORD];
    wire          g_xfer    = node[win_idx][`IET_N_XFER] &
                              (g_cont | (cnt[gch] != {CW{1'b0}})); // [RULE1] [RULE6]
    wire          take_trap = (state == ST_IDLE) & trap_pend; // [RULE14]
    wire          grant     = (state == ST_IDLE) & ~trap_pend & win_ok;
    wire [3:0]    lat_m1    = (jc ? `IET_RESP_JC : `IET_RESP_NC) - 4'h1; // [RULE8]
    wire [AW-1:0] step      = {{(AW-2){1'b0}}, g_word, ~g_word};
    wire          last_one  = (cnt[gch] == {{(CW-1){1'b0}}, 1'b1});
    wire [7:0]    zero_ev   = (grant & g_xfer & ~g_cont & last_one) ?
                              (8'h01 << gch) : 8'h00;
    wire [8:0]    clr_mask  = (wr && !node_sel && !ch_sel && paddr == `IET_CLR) ?
                              pwdata[8:0] : 9'h000;

    // Registers, service sequencing and bus answer
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            for (j = 0; j < 64; j = j + 1)
                node[j] <= `IET_RST_NODE;
            for (j = 0; j < 8; j = j + 1)
            begin
                sptr[j] <= {AW{1'b0}};
                dptr[j] <= {AW{1'b0}};
                cnt[j]  <= {CW{1'b0}};
                cctl[j] <= 4'h0;
            end
            jc          <= 1'b0;
            ssel        <= 16'h0000;
            etlc        <= 8'h00;
            route       <= 16'h0000;
            pat         <= `IET_RST_W32;
            gate        <= 8'h00;
            stat        <= 9'h000;
            ien         <= 9'h000;
            state       <= ST_IDLE;
            rcnt        <= 4'h0;
            trap_pend   <= 1'b0;
            prdata      <= `IET_RST_W32;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            branch      <= 1'b0;
            branch_addr <= {AW{1'b0}};
            xfer_go     <= 1'b0;
            xfer_src    <= {AW{1'b0}};
            xfer_dst    <= {AW{1'b0}};
            xfer_word   <= 1'b0;
            router_trig <= 4'h0;
            irq         <= 1'b0;
        end
        else if (ce)
        begin
            // One wait state, then answer
            pready  <= acc & ~pready;
            pslverr <= acc & ~pready & ~hit;
            if (acc && !pready && !pwrite)
                prdata <= rd_val; // Read data holds until the next read

            // Request flags: source set wins over grant clear and write
            for (j = 0; j < 64; j = j + 1)
            begin
                if (wr && node_sel && nidx == j[5:0])
                    node[j] <= {pwdata[9:1], pwdata[0] | src_eff[j]}; // [RULE9]
                else
                    node[j][`IET_N_REQ] <= src_eff[j] | (node[j][`IET_N_REQ] &
                        ~(grant && win_idx == j[5:0])); // [RULE16]
            end

            // Channel pointers and counters, software write wins
            for (j = 0; j < 8; j = j + 1)
            begin
                if (grant && g_xfer && gch == j[2:0]) // [RULE7]
                begin
                    if (cctl[j][`IET_C_INCS])
                        sptr[j] <= sptr[j] + step; // [RULE4]
                    if (cctl[j][`IET_C_INCD])
                        dptr[j] <= dptr[j] + step; // [RULE4]
                    if (!cctl[j][`IET_C_CONT])
                        cnt[j] <= cnt[j] - {{(CW-1){1'b0}}, 1'b1}; // [RULE5]
                end
                if (wr && ch_sel && cidx == j[2:0])
                begin
                    case (creg)
                        `IET_CR_SRC: sptr[j] <= pwdata[AW-1:0];
                        `IET_CR_DST: dptr[j] <= pwdata[AW-1:0];
                        `IET_CR_CNT: cnt[j]  <= pwdata[CW-1:0];
                        default:     cctl[j] <= pwdata[3:0];
                    endcase
                end
            end

            // Configuration writes
            if (wr && !node_sel && !ch_sel)
            begin
                case (paddr)
                    `IET_CFG:   jc    <= pwdata[0];
                    `IET_SSEL:  ssel  <= pwdata[15:0];
                    `IET_ETLC:  etlc  <= pwdata[7:0];
                    `IET_ROUTE: route <= pwdata[15:0];
                    `IET_PAT:   pat   <= pwdata;
                    `IET_GATE:  gate  <= pwdata[7:0];
                    `IET_IEN:   ien   <= pwdata[8:0];
                    default:    jc    <= jc;
                endcase
            end

            // Sticky status, set wins over clear, and interrupt line
            stat      <= (stat & ~clr_mask) | {take_trap, zero_ev};
            irq       <= |(stat & ien);
            trap_pend <= trap_req | (trap_pend & ~take_trap);
            router_trig <= next_trig;

            // Service sequencing
            branch  <= 1'b0;
            xfer_go <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (take_trap)
                    begin
                        state       <= ST_RESP; // [RULE14]
                        rcnt        <= lat_m1;
                        branch_addr <= TRAP_VEC;
                    end
                    else if (grant && g_xfer)
                    begin
                        xfer_go   <= 1'b1; // [RULE3]
                        xfer_src  <= sptr[gch];
                        xfer_dst  <= dptr[gch];
                        xfer_word <= g_word;
                    end
                    else if (grant)
                    begin
                        state       <= ST_RESP;
                        rcnt        <= lat_m1;
                        branch_addr <= VEC_BASE +
                            {{(AW-8){1'b0}}, win_idx, 2'b00}; // [RULE2] [RULE6]
                    end
                end
                ST_RESP:
                begin
                    if (rcnt == 4'h1)
                    begin
                        branch <= 1'b1; // [RULE2] [RULE8]
                        state  <= ST_IDLE;
                    end
                    else
                        rcnt <= rcnt - 4'h1;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
endmodule // iet_top

/* iet_monitor.sv */
// Port timing checker of the interrupt and transfer block
`timescale 1ns/100ps
module iet_monitor
(
    // Clock, reset and enable
    input wire        clock,
    input wire        rst_n,
    input wire        ce,
    // Register bus
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // Core side
    input wire        branch,
    input wire        xfer_go
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Bus answer comes after one wait state and lasts one cycle
    chk_ready_wait: assert property (psel && $rose(penable) && ce |=> pready)
        else $error("bus answer not after one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("bus answer longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error flag without answer");
    chk_read_hold: assert property ((!psel || pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    // Services are single pulses and never overlap
    chk_branch_pulse: assert property (branch |=> !branch)
        else $error("branch longer than one cycle");
    chk_xfer_pulse: assert property (xfer_go |=> !xfer_go)
        else $error("transfer longer than one cycle");
    chk_xfer_alone: assert property (xfer_go |-> !branch)
        else $error("transfer together with branch");
    // Response counting keeps branches at least seven cycles apart
    chk_branch_gap: assert property (branch |=> !branch [*6])
        else $error("branches closer than response time");
    cov_branch: cover property (branch);
    cov_xfer: cover property (xfer_go);
    cov_slverr: cover property (pslverr);
endmodule // iet_monitor

bind iet_top iet_monitor u_iet_monitor
(
    .clock   (clock),
    .rst_n   (rst_n),
    .ce      (ce),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .branch  (branch),
    .xfer_go (xfer_go)
);

/* iet_core_model.sv */
// Behavioural core that takes forced branches and stolen cycles
`timescale 1ns/100ps
module iet_core_model
(
    // Clock and reset
    input  wire       clock,
    input  wire       rst_n,
    // Service strobes
    input  wire       branch,
    input  wire       xfer_go,
    // Services seen
    output reg  [7:0] n_branch,
    output reg  [7:0] n_xfer
);
    // One vector fetch per branch pulse, one stolen cycle per transfer
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            n_branch <= 8'h00;
            n_xfer   <= 8'h00;
        end
        else
        begin
            n_branch <= n_branch + {7'h00, branch};
            n_xfer   <= n_xfer + {7'h00, xfer_go};
        end
    end
endmodule // iet_core_model

/* tb_top.sv */
// Self-checking bench of the interrupt and transfer block
`timescale 1ns/100ps
`include "iet_defs.vh"
module tb_top;
    reg         clock;
    reg         rst_n;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    reg  [63:0] src_req;
    reg  [3:0]  router_in;
    reg  [7:0]  alt_src;
    reg         trap_req;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        branch;
    wire [15:0] branch_addr;
    wire        xfer_go;
    wire [15:0] xfer_src;
    wire [15:0] xfer_dst;
    wire        xfer_word;
    wire [3:0]  router_trig;
    wire        irq;
    wire [7:0]  n_branch;
    wire [7:0]  n_xfer;
    int         miscompares = 0;
    int         compares = 0;
    int         cycles = 0;
    int         n;
    reg  [31:0] rd;
    reg         err;

    iet_top u_iet_top (.clock(clock), .rst_n(rst_n), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
        .alt_src(alt_src), .router_in(router_in), .trap_req(trap_req), .branch(branch),
        .branch_addr(branch_addr), .xfer_go(xfer_go), .xfer_src(xfer_src),
        .xfer_dst(xfer_dst), .xfer_word(xfer_word), .router_trig(router_trig), .irq(irq));
    iet_core_model u_iet_core_model (.clock(clock), .rst_n(rst_n), .branch(branch),
        .xfer_go(xfer_go), .n_branch(n_branch), .n_xfer(n_xfer));

    // Clock and hang guard
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            print_verdict;
        end
    end

    task print_verdict;
    begin
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    task check(input [31:0] seen, input [31:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask

    // One bus transfer, held until the answer is sampled
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // pready ends this wait; only the bench timeout ends a hang
        do
        begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    // One-cycle request pulse, then count cycles to a service strobe
    task fire(input [63:0] r, input t);
    begin
        @(posedge clock);
        src_req  <= r;
        trap_req <= t;
        @(posedge clock);
        src_req  <= 64'h0;
        trap_req <= 1'b0;
    end
    endtask
    task wait_ev(input int w);
    begin
        n = 0;
        do
        begin
            @(posedge clock);
            #1;
            n = n + 1;
        end while ((w == 0 ? branch : w == 1 ? xfer_go : router_trig[0]) !== 1'b1 && n < 40);
    end
    endtask

    task t_regs;
    begin
        apb(0, 12'h0FC, 32'h0);
        check(rd, 32'h0);
        apb(1, 12'h014, 32'h0000_03FC);
        apb(0, 12'h014, 32'h0);
        check(rd, 32'h0000_03FC);
        apb(0, 12'h300, 32'h0);
        check({err, rd[30:0]}, 32'h8000_0000);
        apb(0, `IET_CLR, 32'h0);
        check({err, rd[30:0]}, 32'h0);
    end
    endtask

    task t_irq(input [31:0] jc, input int lat);
    begin
        apb(1, `IET_CFG, jc);
        apb(1, 12'h00C, 32'h0000_000A);
        fire(64'h8, 1'b0);
        wait_ev(0);
        check(n, lat);
        check(branch_addr, 32'h0000_000C);
        apb(0, 12'h00C, 32'h0);
        check(rd, 32'h0000_000A);
    end
    endtask

    // Two nodes at once plus one disabled node
    task t_prio;
    begin
        apb(1, 12'h028, 32'h0000_0006);
        apb(1, 12'h050, 32'h0000_0016);
        fire(64'h4010_0400, 1'b0);
        wait_ev(0);
        check(branch_addr, 32'h0000_0050);
        wait_ev(0);
        check(branch_addr, 32'h0000_0028);
        wait_ev(0);
        check(n, 40);
    end
    endtask

    task t_chan(input [11:0] cb, input [11:0] na, input [31:0] nv, input [63:0] r,
                input [31:0] ctl, input [31:0] ss, input [31:0] ds, input [31:0] left);
    begin
        apb(1, cb, 32'h0000_1000);
        apb(1, cb + 12'h004, 32'h0000_2000);
        apb(1, cb + 12'h008, ctl[2] ? left : left + 2);
        apb(1, cb + 12'h00C, ctl);
        apb(1, na, nv);
        for (int i = 0; i < 2; i++)
        begin
            fire(r, 1'b0);
            wait_ev(1);
            check(n, 1);
            check(xfer_src, 32'h0000_1000 + ss * i);
            check(xfer_dst, 32'h0000_2000 + ds * i);
            check(xfer_word, ctl[3]);
        end
        apb(0, cb + 12'h008, 32'h0);
        check(rd, left);
    end
    endtask

    // Exhausted channel turns the next request into an interrupt
    task t_zero;
    begin
        apb(1, `IET_IEN, 32'h0000_0004);
        fire(64'h80, 1'b0);
        wait_ev(0);
        check(n, 7);
        check({branch_addr, n_xfer}, 32'h001C_02);
        apb(0, `IET_STAT, 32'h0);
        check({irq, rd[2]}, 32'h3);
        apb(1, `IET_CLR, 32'h0000_0004);
        apb(0, `IET_STAT, 32'h0);
        check({irq, rd[2]}, 32'h0);
    end
    endtask

    task t_trap;
    begin
        fire(64'h0, 1'b1);
        wait_ev(0);
        check({n[7:0], branch_addr}, 32'h07_0100);
        apb(0, `IET_STAT, 32'h0);
        check(rd[8], 32'h1);
        check(n_branch, 32'h6);
    end
    endtask

    // Edge selection, gating mode, then a shared node fed by the router
    task r_try(input [31:0] edg, input [31:0] mode, input lv, input exp);
    begin
        apb(1, 12'h108, edg);
        apb(1, `IET_GATE, mode);
        @(posedge clock);
        router_in <= {3'b000, lv};
        wait_ev(2);
        check(n < 40, exp);
    end
    endtask
    task t_router;
    begin
        apb(1, `IET_ROUTE, 32'h0000_0001);
        r_try(32'h01, 32'h0, 1'b1, 1'b0);
        r_try(32'h01, 32'h1, 1'b0, 1'b0);
        r_try(32'h01, 32'h1, 1'b1, 1'b1);
        r_try(32'h10, 32'h2, 1'b0, 1'b1);
        r_try(32'h11, 32'h3, 1'b1, 1'b0);
        // Pattern on input 0: match only while it is low
        apb(1, `IET_PAT, 32'h0000_0001);
        r_try(32'h11, 32'h2, 1'b0, 1'b1);
        r_try(32'h11, 32'h2, 1'b1, 1'b0);
        apb(1, `IET_SSEL, 32'h0000_0001);
        apb(1, 12'h0E0, 32'h0000_0002);
        @(posedge clock);
        router_in <= 4'h0;
        wait_ev(0);
        check(branch_addr, 32'h0000_00E0);
        // Node 57 fed by its alternate source
        apb(1, `IET_SSEL, 32'h0000_0008);
        apb(1, 12'h0E4, 32'h0000_0002);
        @(posedge clock);
        alt_src <= 8'h02;
        @(posedge clock);
        alt_src <= 8'h00;
        wait_ev(0);
        check(branch_addr, 32'h0000_00E4);
    end
    endtask

    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        src_req = 64'h0;
        router_in = 4'h0;
        alt_src = 8'h00;
        trap_req = 1'b0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        t_regs;
        t_irq(32'h0, 11);
        t_irq(32'h1, 7);
        t_prio;
        t_chan(12'h220, 12'h01C, 32'h0000_0142, 64'h80, 32'h0000_000B, 2, 2, 0);
        t_zero;
        t_chan(12'h210, 12'h020, 32'h0000_00C2, 64'h100, 32'h0000_0006, 0, 1, 5);
        t_trap;
        t_router;
        print_verdict;
    end
endmodule // tb_top
